// ### peq_regs.svh
// Purpose: Register map, field positions, reset values and sizes of the pulse event qualifier
// Assumes: Word-indexed register port, 16-bit data
// Notes:   Definitions only
`ifndef PEQ_REGS_SVH
`define PEQ_REGS_SVH

// Register indices
`define PEQ_REG_CTRL      4'h0
`define PEQ_REG_THRESH    4'h1
`define PEQ_REG_END_HYST  4'h2
`define PEQ_REG_START_ARM 4'h3
`define PEQ_REG_END_ARM   4'h4
`define PEQ_REG_MEAN_LEN  4'h5
`define PEQ_REG_DET_LEN   4'h6
`define PEQ_REG_COIN_LEN  4'h7
`define PEQ_REG_MASKS     4'h8
`define PEQ_REG_EDGE_WIN  4'h9
`define PEQ_REG_CMD       4'ha
`define PEQ_REG_STATUS    4'hb

// Control fields
`define PEQ_CTRL_NEG      0
`define PEQ_CTRL_PRE_EN   1
`define PEQ_CTRL_POST_EN  2
`define PEQ_CTRL_SRC_LO   4
`define PEQ_CTRL_SRC_HI   6
`define PEQ_CMD_SW_EXTERNAL_EVENT_INPUT   0

// Reset values
`define PEQ_RST_CTRL      16'h0000
`define PEQ_RST_THRESH    16'h0000
`define PEQ_RST_HYST      16'h0000
`define PEQ_RST_ARM       16'h0000
`define PEQ_RST_MEAN_LEN  8'h00
`define PEQ_RST_DET_LEN   16'h0100
`define PEQ_RST_COIN_LEN  16'h0010
`define PEQ_RST_MASKS     16'h8421
`define PEQ_RST_EDGE_WIN  16'h0000

// Edge window sizes
`define PEQ_ROI_DLY       16
`define PEQ_PTR_W         4

`endif

// ### peq_pkg.sv
// Purpose: Types shared by the pulse event qualifier
// Assumes: Four channels of 16-bit signed samples
// Notes:   Constants live in peq_regs.svh
package peq_pkg;

  typedef logic signed [15:0] peq_sample_t;   // Baseline-corrected ADC code
  typedef logic signed [17:0] peq_level_t;    // Widened level, no overflow on sums

  // Source that opens the detection window
  typedef enum logic [2:0] {
    PEQ_SRC_ALWAYS   = 3'b000,
    PEQ_SRC_SOFTWARE = 3'b001,
    PEQ_SRC_INTERNAL = 3'b010,
    PEQ_SRC_EXTERNAL = 3'b011,
    PEQ_SRC_LEVEL    = 3'b100
  } peq_src_t;

  // Pulse tracking state per channel
  typedef enum logic [0:0] {
    PEQ_IDLE  = 1'b0,
    PEQ_PULSE = 1'b1
  } peq_pulse_st_t;

  // Per-channel result bundle
  typedef struct packed {
    logic        start_evt;  // Start event, undelayed
    logic        end_evt;    // End event, undelayed
    logic        accepted;   // Start event that passed window and coincidence
    logic        roi;        // Region of interest, aligned to roi_sample
    peq_sample_t roi_sample; // Sample delayed by the edge window depth
  } peq_chan_out_t;

endpackage : peq_pkg

// ### peq_qualifier.sv
// Purpose: Pulse start/end detection, detection window and coincidence for four channels
// Assumes: One sample per mclk on every channel, running mean supplied from outside
// Notes:   Region of interest is reported on a stream delayed by PEQ_ROI_DLY samples
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "peq_regs.svh"

module peq_qualifier (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [15:0]               reg_rdata,
  input  peq_pkg::peq_sample_t [3:0]     sample_in,
  input  peq_pkg::peq_sample_t [3:0]     running_mean_result,
  input  wire logic                      internal_trigger,
  input  wire logic                      external_event_input,
  output peq_pkg::peq_chan_out_t [3:0]   chan_out
);

  // Configuration registers
  logic [15:0]        ctrl_q;       // Polarity, edge enables, window source
  logic [15:0]        thresh_q;     // Event threshold
  logic [15:0]        hyst_q;       // End hysteresis
  logic [15:0]        start_arm_q;  // Start rearm margin
  logic [15:0]        end_arm_q;    // End rearm margin
  logic [7:0]         mean_len_q;   // Running mean length, zero disables the filter
  logic [15:0]        det_len_q;    // Detection window length in samples
  logic [15:0]        coin_len_q;   // Coincidence window length in samples
  logic [15:0]        masks_q;      // Four dependency masks, channel A in [3:0]
  logic [15:0]        edge_win_q;   // Pre length [3:0], post length [15:8]
  logic               sw_external_event_input;      // Software window command this cycle

  // Per-channel detection state
  peq_pkg::peq_pulse_st_t [3:0] st_q;
  logic [3:0]         start_armed_q;
  logic [3:0]         end_armed_q;
  logic [3:0]         start_evt;
  logic [3:0]         end_evt;
  logic [3:0]         win_open;     // Detection window open, including opening cycle
  logic [3:0]         coin_win;     // Stretched start, including its own cycle
  logic [3:0]         accept;
  logic [15:0]        det_cnt_q [4];
  logic [15:0]        coin_cnt_q [4];

  // Levels per channel
  peq_pkg::peq_level_t thr   [4];
  peq_pkg::peq_level_t endl  [4];
  peq_pkg::peq_level_t sarm  [4];
  peq_pkg::peq_level_t earm  [4];
  peq_pkg::peq_level_t smp   [4];

  // Edge window delay line
  peq_pkg::peq_sample_t dly_mem_q [4][`PEQ_ROI_DLY];
  logic [`PEQ_PTR_W-1:0] dly_ptr_q;
  logic [`PEQ_ROI_DLY-1:0] start_sr_q [4];
  logic [`PEQ_ROI_DLY-1:0] pulse_sr_q [4];
  logic [7:0]         post_cnt_q [4];
  logic [3:0]         pre_hit;

  peq_pkg::peq_src_t  src;
  logic               neg;
  logic               common_open;

  assign neg = ctrl_q[`PEQ_CTRL_NEG];
  assign src = peq_pkg::peq_src_t'(ctrl_q[`PEQ_CTRL_SRC_HI:`PEQ_CTRL_SRC_LO]);
  assign sw_external_event_input = reg_wr && (reg_addr == `PEQ_REG_CMD) && reg_wdata[`PEQ_CMD_SW_EXTERNAL_EVENT_INPUT];

  // Sign-extend a 16-bit code to the level width
  function automatic peq_pkg::peq_level_t ext16(input logic [15:0] v);
    ext16 = {{2{v[15]}}, v};
  endfunction : ext16

  // True when a is at or beyond b in the pulse direction
  function automatic logic beyond(input peq_pkg::peq_level_t a, input peq_pkg::peq_level_t b,
                                  input logic n);
    beyond = n ? (a <= b) : (a >= b);
  endfunction : beyond

  // Level computation; 18-bit math keeps sums from wrapping at the code limits
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      smp[c] = ext16(sample_in[c]);
      if (mean_len_q == 8'h00) begin
        thr[c] = ext16(thresh_q);
      end else begin
        thr[c] = ext16(running_mean_result[c]) + ext16(thresh_q);
      end
      endl[c] = neg ? thr[c] + ext16(hyst_q) : thr[c] - ext16(hyst_q);
      sarm[c] = neg ? thr[c] + ext16(start_arm_q) : thr[c] - ext16(start_arm_q);
      earm[c] = neg ? endl[c] - ext16(end_arm_q) : endl[c] + ext16(end_arm_q);
    end
  end

  // Start and end events from the current sample
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // Start only when idle and armed
      start_evt[c] = (st_q[c] == peq_pkg::PEQ_IDLE) && start_armed_q[c] && beyond(smp[c], thr[c], neg);
      // End when the sample returns to the end level
      end_evt[c] = (st_q[c] == peq_pkg::PEQ_PULSE) && end_armed_q[c] && beyond(endl[c], smp[c], neg);
    end
  end

  // Pulse state and arming; a start disarms until the signal falls back past the arm level
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < 4; c++) begin
        st_q[c] <= peq_pkg::PEQ_IDLE;
      end
      start_armed_q <= 4'h0;
      end_armed_q   <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        case (st_q[c])
          peq_pkg::PEQ_IDLE: begin
            if (start_evt[c]) begin
              st_q[c]          <= peq_pkg::PEQ_PULSE;
              start_armed_q[c] <= 1'b0;
              end_armed_q[c]   <= !beyond(earm[c], smp[c], neg);
            end else if (!beyond(smp[c], sarm[c], neg)) begin
              start_armed_q[c] <= 1'b1;
            end
          end
          peq_pkg::PEQ_PULSE: begin
            if (end_evt[c]) begin
              st_q[c]        <= peq_pkg::PEQ_IDLE;
              end_armed_q[c] <= 1'b0;
              start_armed_q[c] <= !beyond(smp[c], sarm[c], neg);
            end else if (!beyond(earm[c], smp[c], neg)) begin
              end_armed_q[c] <= 1'b1;
            end
          end
          default: begin
            st_q[c] <= peq_pkg::PEQ_IDLE;
          end
        endcase
      end
    end
  end

  // Common opening: software, internal or external source
  always_comb begin
    case (src)
      peq_pkg::PEQ_SRC_SOFTWARE: common_open = sw_external_event_input;
      peq_pkg::PEQ_SRC_INTERNAL: common_open = internal_trigger;
      peq_pkg::PEQ_SRC_EXTERNAL: common_open = external_event_input;
      default:                   common_open = 1'b0;
    endcase
  end

  // Window flags; each is open in its opening cycle already
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      if (src == peq_pkg::PEQ_SRC_ALWAYS) begin
        win_open[c] = 1'b1;
      end else if (src == peq_pkg::PEQ_SRC_LEVEL) begin
        win_open[c] = (det_cnt_q[c] != 16'h0000) || start_evt[c];
      end else begin
        win_open[c] = (det_cnt_q[c] != 16'h0000) || common_open;
      end
      coin_win[c] = (coin_cnt_q[c] != 16'h0000) || start_evt[c];
    end
  end

  // Coincidence: own start AND any masked stretched window
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // Mask bit i selects channel i, D at bit 3
      accept[c] = start_evt[c] && win_open[c] && |(masks_q[4*c +: 4] & coin_win);
    end
  end

  // Window counters; length is the same whatever opened the window
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int c = 0; c < 4; c++) begin
        det_cnt_q[c]  <= 16'h0000;
        coin_cnt_q[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        // A new opening inside an open window does not extend it
        if (det_cnt_q[c] != 16'h0000) begin
          det_cnt_q[c] <= det_cnt_q[c] - 16'h0001;
        end else if ((src == peq_pkg::PEQ_SRC_LEVEL && start_evt[c]) ||
                     (src != peq_pkg::PEQ_SRC_LEVEL && common_open)) begin
          det_cnt_q[c] <= (det_len_q == 16'h0000) ? 16'h0000 : det_len_q - 16'h0001;
        end
        // Each start restarts the stretch; spacing below the length coincides
        if (start_evt[c]) begin
          coin_cnt_q[c] <= (coin_len_q == 16'h0000) ? 16'h0000 : coin_len_q - 16'h0001;
        end else if (coin_cnt_q[c] != 16'h0000) begin
          coin_cnt_q[c] <= coin_cnt_q[c] - 16'h0001;
        end
      end
    end
  end

  // Pre-window: an upcoming start within pre length of the oldest sample
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      pre_hit[c] = 1'b0;
      for (int j = 1; j < `PEQ_ROI_DLY; j++) begin
        if (j <= int'(edge_win_q[3:0]) && start_sr_q[c][`PEQ_ROI_DLY-1-j]) begin
          pre_hit[c] = 1'b1;
        end
      end
    end
  end

  // Delay line and post-window counters; delay keeps the pre-window causal
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dly_ptr_q <= '0;
      for (int c = 0; c < 4; c++) begin
        start_sr_q[c] <= '0;
        pulse_sr_q[c] <= '0;
        post_cnt_q[c] <= 8'h00;
        for (int k = 0; k < `PEQ_ROI_DLY; k++) begin
          dly_mem_q[c][k] <= 16'sh0000;
        end
      end
    end else begin
      dly_ptr_q <= dly_ptr_q + 1'b1;
      for (int c = 0; c < 4; c++) begin
        dly_mem_q[c][dly_ptr_q] <= sample_in[c];
        start_sr_q[c] <= {start_sr_q[c][`PEQ_ROI_DLY-2:0], start_evt[c]};
        pulse_sr_q[c] <= {pulse_sr_q[c][`PEQ_ROI_DLY-2:0], start_evt[c] || (st_q[c] == peq_pkg::PEQ_PULSE)};
        if (pulse_sr_q[c][`PEQ_ROI_DLY-1] && !pulse_sr_q[c][`PEQ_ROI_DLY-2]) begin
          post_cnt_q[c] <= edge_win_q[15:8];
        end else if (post_cnt_q[c] != 8'h00) begin
          post_cnt_q[c] <= post_cnt_q[c] - 8'h01;
        end
      end
    end
  end

  // Registered per-channel outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_out <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        chan_out[c].start_evt  <= start_evt[c];
        chan_out[c].end_evt    <= end_evt[c];
        chan_out[c].accepted   <= accept[c];
        chan_out[c].roi_sample <= dly_mem_q[c][dly_ptr_q];
        chan_out[c].roi        <= pulse_sr_q[c][`PEQ_ROI_DLY-1] ||
                                  (ctrl_q[`PEQ_CTRL_PRE_EN] && pre_hit[c]) ||
                                  (ctrl_q[`PEQ_CTRL_POST_EN] && post_cnt_q[c] != 8'h00);
      end
    end
  end

  // Register writes; the filter length and delay sum is software's to keep
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q      <= `PEQ_RST_CTRL;
      thresh_q    <= `PEQ_RST_THRESH;
      hyst_q      <= `PEQ_RST_HYST;
      start_arm_q <= `PEQ_RST_ARM;
      end_arm_q   <= `PEQ_RST_ARM;
      mean_len_q  <= `PEQ_RST_MEAN_LEN;
      det_len_q   <= `PEQ_RST_DET_LEN;
      coin_len_q  <= `PEQ_RST_COIN_LEN;
      masks_q     <= `PEQ_RST_MASKS;
      edge_win_q  <= `PEQ_RST_EDGE_WIN;
    end else if (reg_wr) begin
      case (reg_addr)
        `PEQ_REG_CTRL:      ctrl_q      <= reg_wdata;
        `PEQ_REG_THRESH:    thresh_q    <= reg_wdata;
        `PEQ_REG_END_HYST:  hyst_q      <= reg_wdata;
        `PEQ_REG_START_ARM: start_arm_q <= reg_wdata;
        `PEQ_REG_END_ARM:   end_arm_q   <= reg_wdata;
        `PEQ_REG_MEAN_LEN:  mean_len_q  <= reg_wdata[7:0];
        `PEQ_REG_DET_LEN:   det_len_q   <= reg_wdata;
        `PEQ_REG_COIN_LEN:  coin_len_q  <= reg_wdata;
        `PEQ_REG_MASKS:     masks_q     <= reg_wdata;
        `PEQ_REG_EDGE_WIN:  edge_win_q  <= reg_wdata;
        default:            ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped and command read as zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PEQ_REG_CTRL:      reg_rdata <= ctrl_q;
        `PEQ_REG_THRESH:    reg_rdata <= thresh_q;
        `PEQ_REG_END_HYST:  reg_rdata <= hyst_q;
        `PEQ_REG_START_ARM: reg_rdata <= start_arm_q;
        `PEQ_REG_END_ARM:   reg_rdata <= end_arm_q;
        `PEQ_REG_MEAN_LEN:  reg_rdata <= {8'h00, mean_len_q};
        `PEQ_REG_DET_LEN:   reg_rdata <= det_len_q;
        `PEQ_REG_COIN_LEN:  reg_rdata <= coin_len_q;
        `PEQ_REG_MASKS:     reg_rdata <= masks_q;
        `PEQ_REG_EDGE_WIN:  reg_rdata <= edge_win_q;
        `PEQ_REG_STATUS:    reg_rdata <= {4'h0, coin_win, win_open, st_q[3], st_q[2], st_q[1], st_q[0]};
        default:            reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_FIXED_THR: assert property ((mean_len_q == 8'h00) |-> (thr[0] == ext16(thresh_q)))
    else $error("fixed threshold not equal to event threshold");
  AST_DYN_THR: assert property ((mean_len_q != 8'h00) |->
    (thr[1] == ext16(running_mean_result[1]) + ext16(thresh_q)))
    else $error("dynamic threshold wrong");
  AST_START_CMP: assert property (start_evt[0] |-> (neg ? smp[0] <= thr[0] : smp[0] >= thr[0]))
    else $error("start without threshold crossing");
  AST_START_NEG: assert property ((neg && st_q[2] == peq_pkg::PEQ_IDLE && start_armed_q[2] && smp[2] <= thr[2])
    |-> start_evt[2] ##1 chan_out[2].start_evt)
    else $error("negative start missed");
  AST_END_LVL: assert property (endl[0] == (neg ? thr[0] + ext16(hyst_q) : thr[0] - ext16(hyst_q)))
    else $error("end level wrong");
  AST_END_EVT: assert property (end_evt[1] |-> end_armed_q[1] ##1 (st_q[1] == peq_pkg::PEQ_IDLE)
    && chan_out[1].end_evt)
    else $error("end event did not close pulse");
  AST_START_ARMED: assert property (start_evt[3] |-> start_armed_q[3] ##1 !start_armed_q[3])
    else $error("start fired unarmed or stayed armed");
  AST_END_ARMED: assert property ((st_q[0] == peq_pkg::PEQ_PULSE && !end_armed_q[0]) |-> !end_evt[0])
    else $error("end fired unarmed");
  AST_DET_LOAD: assert property ((src == peq_pkg::PEQ_SRC_EXTERNAL && common_open && det_cnt_q[0] == 16'h0000
    && det_len_q > 16'h0001 && !reg_wr) |=> (det_cnt_q[0] == $past(det_len_q) - 16'h0001) && win_open[0])
    else $error("detection window length wrong");
  AST_COIN_LOAD: assert property ((start_evt[1] && coin_len_q > 16'h0001) |=> coin_win[1])
    else $error("coincidence window not stretched");
  AST_ACCEPT: assert property (chan_out[2].accepted == $past(start_evt[2] && win_open[2] &&
    |(masks_q[11:8] & coin_win)))
    else $error("accept output wrong");
  AST_OWN_BIT: assert property ((start_evt[3] && masks_q[15] && src == peq_pkg::PEQ_SRC_ALWAYS)
    |=> chan_out[3].accepted)
    else $error("own bit did not give independent accept");

  COV_ACCEPT_DEP: cover property (start_evt[1] ##[1:20] (accept[0] && !masks_q[0]));
  COV_PULSE_END: cover property (start_evt[0] ##[1:50] end_evt[0]);
  COV_LEVEL_WIN: cover property (src == peq_pkg::PEQ_SRC_LEVEL && start_evt[2] && det_cnt_q[2] == 16'h0000);
  COV_ROI_PRE: cover property (ctrl_q[`PEQ_CTRL_PRE_EN] && pre_hit[0]);

endmodule : peq_qualifier

// ### peq_source.sv
// Purpose: Far-side model: sample stream, running mean and external event input
// Assumes: Bench changes levels by non-blocking assignment just after a rising edge
// Notes: Running mean length plus delay stays at 4, well inside 100
`timescale 1ns/100ps
module peq_source (
  input  wire logic                  mclk,
  input  peq_pkg::peq_sample_t [3:0] lvl,
  input  peq_pkg::peq_sample_t       mean_lvl,
  input  wire logic                  ext_req,
  output peq_pkg::peq_sample_t [3:0] sample_out,
  output peq_pkg::peq_sample_t [3:0] mean_out,
  output logic                       ext_evt
);
  // Samples pass straight through; one new code per clock
  assign sample_out = lvl;
  // One mean for all channels; a short filter keeps length plus delay legal
  assign mean_out = {4{mean_lvl}};
  // External equipment edge is resynchronised, so it lands one cycle late
  always_ff @(posedge mclk) begin
    ext_evt <= ext_req;
  end
endmodule : peq_source

// ### pulse_event_qualifier_tb.sv
// Purpose: Self-checking bench for the pulse event qualifier
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Each pulse test starts from a fresh reset so polarity swaps cannot misfire
`timescale 1ns/100ps
`include "peq_regs.svh"
module pulse_event_qualifier_tb;
  logic                         mclk, sys_rst, reg_wr, reg_rd, internal_trigger, ext_req, external_event_input;
  logic [3:0]                   reg_addr;
  logic [15:0]                  reg_wdata, reg_rdata, rd_val;
  peq_pkg::peq_sample_t [3:0]   lvl, sample_in, running_mean_result;
  peq_pkg::peq_sample_t         mean_lvl;
  peq_pkg::peq_chan_out_t [3:0] chan_out;
  int                           n_errors, num_checks, seed, t, h, cnt;
  // Coincidence table: mask of A, other channel, start spacing, expected accept
  logic [3:0] cm[6] = '{4'h2, 4'h2, 4'h2, 4'ha, 4'ha, 4'h3};
  int         co[6] = '{1, 1, 1, 3, 2, 2};
  int         cd[6] = '{0, 4, 5, 3, 1, 9};
  logic       ce[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  peq_qualifier peq_qualifier_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in),
    .running_mean_result(running_mean_result), .internal_trigger(internal_trigger),
    .external_event_input(external_event_input), .chan_out(chan_out));
  peq_source peq_source_inst (.mclk(mclk), .lvl(lvl), .mean_lvl(mean_lvl), .ext_req(ext_req),
    .sample_out(sample_in), .mean_out(running_mean_result), .ext_evt(external_event_input));

  // 25 MHz sample clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Compare and count; four-state compare so unknowns fail
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // One-cycle register write
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read; data is taken in the following cycle only
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rd_val = reg_rdata;
  endtask : rd

  // New sample on selected channels; outputs seen afterwards belong to the previous sample
  task drive(input logic [3:0] hi, input logic [15:0] v);
    @(posedge mclk);
    for (int c = 0; c < 4; c++) lvl[c] <= hi[c] ? v : 16'h0000;
    @(negedge mclk);
  endtask : drive

  // Fresh reset, then threshold, hysteresis and control, then one arming sample
  task setup(input logic [15:0] ctl, input logic [15:0] thr, input logic [15:0] hy);
    @(posedge mclk);
    sys_rst <= 1'b1; lvl <= '0;
    @(posedge mclk);
    sys_rst <= 1'b0;
    wr(`PEQ_REG_THRESH, thr);
    wr(`PEQ_REG_END_HYST, hy);
    wr(`PEQ_REG_CTRL, ctl);
    drive(4'hf, 16'h0000);
  endtask : setup

  // Single-sample pulse on all channels, acceptance of channel A compared
  task shot(input logic e);
    drive(4'hf, 16'h0078);
    drive(4'hf, 16'h0000);
    chk("accepted", {15'h0000, e}, chan_out[0].accepted);
    drive(4'hf, 16'h0000);
  endtask : shot

  // Full pulse with exact boundary samples, either polarity
  task pulse(input logic neg, input int th, input int hy);
    int s, tt;
    s = neg ? -1 : 1;
    tt = s * th;
    setup({15'h0000, neg}, tt[15:0], hy[15:0]);
    drive(4'hf, 16'(tt - s));
    drive(4'hf, tt[15:0]);
    chk("start early", 16'h0000, chan_out[0].start_evt);
    drive(4'hf, 16'(tt + 5 * s));
    chk("start", 16'h0001, chan_out[0].start_evt);
    chk("accept", 16'h0001, chan_out[0].accepted);
    drive(4'hf, 16'(tt - s * (hy - 1)));
    chk("retrigger", 16'h0000, chan_out[0].start_evt);
    drive(4'hf, 16'(tt - s * hy));
    chk("end early", 16'h0000, chan_out[0].end_evt);
    drive(4'hf, 16'h0000);
    chk("end", 16'h0001, chan_out[0].end_evt);
  endtask : pulse

  // Hang guard: running out counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end

  initial begin
    seed = 15548; n_errors = 0; num_checks = 0;
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    internal_trigger = 1'b0; ext_req = 1'b0; mean_lvl = 16'h0000; lvl = '0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`PEQ_REG_MASKS); chk("masks", 16'h8421, rd_val);
    rd(`PEQ_REG_COIN_LEN); chk("coin len", 16'h0010, rd_val);
    rd(4'hc); chk("unmapped", 16'h0000, rd_val);
    $display("test registers done");
    // Random thresholds and hysteresis, four of each polarity
    for (int i = 0; i < 8; i++) begin
      t = 2 + {$random(seed)} % 900;
      h = 2 + {$random(seed)} % 40;
      pulse(i >= 4, t, h);
    end
    $display("test pulses done");
    // Dynamic threshold follows the mean, then fixed absolute threshold
    setup(16'h0000, 16'h0064, 16'h000a);
    wr(`PEQ_REG_MEAN_LEN, 16'h0004);
    mean_lvl <= 16'h0032;
    drive(4'hf, 16'h0095); drive(4'hf, 16'h0096);
    chk("mean below", 16'h0000, chan_out[0].start_evt);
    drive(4'hf, 16'h0000);
    chk("mean start", 16'h0001, chan_out[0].start_evt);
    wr(`PEQ_REG_MEAN_LEN, 16'h0000);
    drive(4'hf, 16'h0064); drive(4'hf, 16'h0000);
    chk("fixed start", 16'h0001, chan_out[0].start_evt);
    // Start arm margin of 20: 85 does not rearm, 79 does
    setup(16'h0000, 16'h0064, 16'h000a);
    wr(`PEQ_REG_START_ARM, 16'h0014);
    drive(4'hf, 16'h0078); drive(4'hf, 16'h0055); drive(4'hf, 16'h0078); drive(4'hf, 16'h004f);
    chk("disarmed", 16'h0000, chan_out[0].start_evt);
    drive(4'hf, 16'h0078); drive(4'hf, 16'h0000);
    chk("rearmed", 16'h0001, chan_out[0].start_evt);
    // End arm margin of 20: end only after passing 110
    setup(16'h0000, 16'h0064, 16'h000a);
    wr(`PEQ_REG_END_ARM, 16'h0014);
    drive(4'hf, 16'h0064); drive(4'hf, 16'h0050); drive(4'hf, 16'h0078);
    chk("end disarmed", 16'h0000, chan_out[0].end_evt);
    // All channels in pulse, window always open, coincidence stretch still running
    rd(`PEQ_REG_STATUS); chk("status", 16'h0fff, rd_val);
    drive(4'hf, 16'h0050); drive(4'hf, 16'h0000);
    chk("end armed", 16'h0001, chan_out[0].end_evt);
    $display("test levels done");
    // Software, internal, external sources: closed, opened, expired; level opens on its start
    for (int s = 1; s < 5; s++) begin
      setup({9'h000, s[2:0], 4'h0}, 16'h0064, 16'h000a);
      wr(`PEQ_REG_DET_LEN, 16'h0008);
      shot(s == 4);
      if (s == 1) wr(`PEQ_REG_CMD, 16'h0001);
      @(posedge mclk);
      internal_trigger <= (s == 2);
      ext_req <= (s == 3);
      @(posedge mclk);
      internal_trigger <= 1'b0;
      ext_req <= 1'b0;
      shot(1'b1);
      repeat (10) drive(4'hf, 16'h0000);
      shot(s == 4);
    end
    $display("test windows done");
    // Coincidence table with a window of 5
    setup(16'h0000, 16'h0064, 16'h000a);
    wr(`PEQ_REG_COIN_LEN, 16'h0005);
    for (int r = 0; r < 6; r++) begin
      wr(`PEQ_REG_MASKS, {12'h842, cm[r]});
      repeat (8) drive(4'hf, 16'h0000);
      for (int i = 0; i <= cd[r]; i++) drive(((i == 0) ? 4'h1 << co[r] : 4'h0) | {3'h0, i == cd[r]}, 16'h0078);
      drive(4'hf, 16'h0000);
      chk("coincidence", {15'h0000, ce[r]}, chan_out[0].accepted);
    end
    $display("test coincidence done");
    // Region length without and with pre 2 and post 3 windows
    for (int k = 0; k < 2; k++) begin
      setup((k == 1) ? 16'h0006 : 16'h0000, 16'h0064, 16'h000a);
      wr(`PEQ_REG_EDGE_WIN, 16'h0302);
      cnt = 0;
      h = 0;
      for (int j = 0; j < 45; j++) begin
        drive(4'hf, (j == 5 || j == 6) ? 16'h0078 : (j == 7) ? 16'h0050 : 16'h0000);
        cnt += (chan_out[0].roi === 1'b1);
        // Region flag must line up with the delayed peak samples
        h += (chan_out[0].roi === 1'b1 && chan_out[0].roi_sample === 16'sh0078);
      end
      chk("roi length", (k == 1) ? 16'h0008 : 16'h0003, cnt[15:0]);
      chk("roi sample", 16'h0002, h[15:0]);
    end
    $display("test region done");
    final_report();
  end
endmodule : pulse_event_qualifier_tb
